// ### rtl/irxf_pkg.sv
package irxf_pkg;
  // ***************************
  // register map
  // ***************************
  localparam int          IRXF_NUM_CTX       = 4;
  localparam logic [15:0] IRXF_PTR_OFFSET    = 16'h040C;
  localparam logic [15:0] IRXF_MATCH_OFFSET  = 16'h410C;
  localparam logic [15:0] IRXF_CTX_STRIDE    = 16'h0020;
  localparam logic [31:0] IRXF_PTR_RESET     = 32'h0000_0000;
  localparam logic [31:0] IRXF_MATCH_RESET   = 32'h0000_0000;
  // writable bits of the match register, 27 and 7 held at zero
  localparam logic [31:0] IRXF_MATCH_WMASK   = 32'hF7FF_F77F | 32'h0000_0800;
  // ***************************
  // match register fields
  // ***************************
  localparam int          IRXF_TAG_EN_LO     = 28;
  localparam int          IRXF_RSVD_HI_BIT   = 27;
  localparam int          IRXF_CYCLE_HI      = 26;
  localparam int          IRXF_CYCLE_LO      = 12;
  localparam int          IRXF_SYNC_HI       = 11;
  localparam int          IRXF_SYNC_LO       = 8;
  localparam int          IRXF_RSVD_LO_BIT   = 7;
  localparam int          IRXF_GATE_BIT      = 6;
  localparam int          IRXF_CHAN_HI       = 5;
  // ***************************
  // codes
  // ***************************
  localparam logic [1:0]  IRXF_TAG_01        = 2'h1;
  localparam logic [1:0]  IRXF_WAIT_SYNC     = 2'h3;
  localparam logic [1:0]  IRXF_GATE_SYNC_TOP = 2'h0;

  typedef enum logic [2:0] {
    IRXF_IDLE      = 3'h1,
    IRXF_WAIT_CYC  = 3'h2,
    IRXF_RECEIVING = 3'h4
  } irxf_state_e;
endpackage

// ### rtl/irxf_ctx_filter.sv
module irxf_ctx_filter
  import irxf_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [31:0] match_word,
  input  wire logic        run,
  input  wire logic        start_on_cycle_enable,
  input  wire logic [1:0]  wait_sel,
  input  wire logic [1:0]  bus_seconds_count,
  input  wire logic [12:0] bus_cycle_index,
  input  wire logic [5:0]  pkt_channel,
  input  wire logic [1:0]  pkt_tag,
  input  wire logic [3:0]  pkt_sync,
  output      logic        accept,
  output      logic        receiving
);
  // ***************************
  // start control
  // ***************************
  irxf_state_e state_reg;
  logic [14:0] now_cycle;
  logic        cycle_hit;

  assign now_cycle = {bus_seconds_count, bus_cycle_index};
  assign cycle_hit = now_cycle == match_word[IRXF_CYCLE_HI:IRXF_CYCLE_LO];

  always_ff @(posedge clk_sys)
  begin
    if (rst || !run)
      state_reg <= IRXF_IDLE;
    else
      case (state_reg)
        IRXF_IDLE:
          state_reg <= start_on_cycle_enable ? IRXF_WAIT_CYC : IRXF_RECEIVING;
        IRXF_WAIT_CYC:
          if (cycle_hit)
            state_reg <= IRXF_RECEIVING;
        default:
          state_reg <= IRXF_RECEIVING;
      endcase
  end

  assign receiving = state_reg[2];

  // ***************************
  // packet match
  // ***************************
  logic tag_ok;
  logic gate_ok;
  logic sync_ok;

  assign tag_ok  = match_word[IRXF_TAG_EN_LO + 32'(pkt_tag)];
  // gate only narrows tag 01b; other tags pass on their enable alone
  assign gate_ok = !(match_word[IRXF_GATE_BIT] && pkt_tag == IRXF_TAG_01)
                   || pkt_sync[3:2] == IRXF_GATE_SYNC_TOP;
  assign sync_ok = wait_sel != IRXF_WAIT_SYNC
                   || pkt_sync == match_word[IRXF_SYNC_HI:IRXF_SYNC_LO];
  assign accept  = receiving && tag_ok && gate_ok && sync_ok
                   && pkt_channel == match_word[IRXF_CHAN_HI:0];

  AST_CYCLE_START: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == IRXF_WAIT_CYC && run && cycle_hit |=> receiving)
    else $error("context did not start on matching cycle");
  AST_CYCLE_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    start_on_cycle_enable && run && !receiving && !cycle_hit ##1 run && !cycle_hit |=> !receiving)
    else $error("context started before matching cycle");
endmodule // irxf_ctx_filter

// ### rtl/irxf_top.sv
// What this block does
// - readable first-descriptor pointer, fetched on run
// - four contexts, registers every 32 bytes
// - tag enables bits 31..28 accept tags
// - match bits 27 and 7 read zero
// - start cycle is seconds[1:0] plus cycle
// - start-on-cycle holds reception until cycle matches
// - sync field must match when wait is 11b
// - gate passes tag 01b only sync top 00b
// - other tags filtered by enable bits only
// - six-bit channel selects accepted channel
// - run bit owned by software, not hardware
module irxf_top
  import irxf_pkg::*;
#(
  parameter int NUM_CTX = IRXF_NUM_CTX
)
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic [15:0]          reg_addr,
  input  wire logic                 reg_wr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_rd,
  output      logic [31:0]          reg_rdata,
  output      logic                 reg_rd_valid,
  input  wire logic [NUM_CTX-1:0]   ctx_run,
  input  wire logic [NUM_CTX-1:0]   start_on_cycle_enable,
  input  wire logic [2*NUM_CTX-1:0] ctx_wait_sel,
  input  wire logic [NUM_CTX-1:0]   ptr_load,
  input  wire logic [31:0]          ptr_value,
  input  wire logic [1:0]           bus_seconds_count,
  input  wire logic [12:0]          bus_cycle_index,
  input  wire logic                 pkt_valid,
  input  wire logic [5:0]           pkt_channel,
  input  wire logic [1:0]           pkt_tag,
  input  wire logic [3:0]           pkt_sync,
  output      logic [NUM_CTX-1:0]   pkt_accept,
  output      logic                 pkt_accept_valid,
  output      logic [NUM_CTX-1:0]   ctx_receiving,
  output      logic [NUM_CTX-1:0]   fetch_start,
  output      logic [31:0]          fetch_addr
);
  // ***************************
  // register storage
  // ***************************
  logic [31:0]        ptr_reg   [NUM_CTX];
  logic [31:0]        match_reg [NUM_CTX];
  logic [NUM_CTX-1:0] run_prev_reg;
  logic [NUM_CTX-1:0] accept_now;
  logic [NUM_CTX-1:0] recv_now;

  always_ff @(posedge clk_sys)
  begin
    for (int n = 0; n < NUM_CTX; n++)
    begin
      if (rst)
        match_reg[n] <= IRXF_MATCH_RESET;
      else if (reg_wr && reg_addr == IRXF_MATCH_OFFSET + 16'(n) * IRXF_CTX_STRIDE)
        match_reg[n] <= reg_wdata & IRXF_MATCH_WMASK;
    end
  end

  // pointer is read-only to software; the descriptor engine loads it
  always_ff @(posedge clk_sys)
  begin
    for (int n = 0; n < NUM_CTX; n++)
    begin
      if (rst)
        ptr_reg[n] <= IRXF_PTR_RESET;
      else if (ptr_load[n])
        ptr_reg[n] <= ptr_value;
    end
  end

  // ***************************
  // register read
  // ***************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rdata    <= 32'h0000_0000;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd;
      reg_rdata    <= 32'h0000_0000;
      for (int n = 0; n < NUM_CTX; n++)
      begin
        if (reg_rd && reg_addr == IRXF_PTR_OFFSET + 16'(n) * IRXF_CTX_STRIDE)
          reg_rdata <= ptr_reg[n];
        else if (reg_rd && reg_addr == IRXF_MATCH_OFFSET + 16'(n) * IRXF_CTX_STRIDE)
          reg_rdata <= match_reg[n] & IRXF_MATCH_WMASK;
      end
    end
  end

  // ***************************
  // descriptor fetch start
  // ***************************
  // run is only watched here, never changed
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      run_prev_reg <= '0;
      fetch_start  <= '0;
      fetch_addr   <= 32'h0000_0000;
    end
    else
    begin
      run_prev_reg <= ctx_run;
      fetch_start  <= ctx_run & ~run_prev_reg;
      // lowest context wins when several start together
      for (int n = NUM_CTX - 1; n >= 0; n--)
      begin
        if (ctx_run[n] && !run_prev_reg[n])
          fetch_addr <= ptr_reg[n];
      end
    end
  end

  // ***************************
  // per-context filters
  // ***************************
  genvar g;
  generate
    for (g = 0; g < NUM_CTX; g++)
    begin : g_ctx
      irxf_ctx_filter u_filter (
        .clk_sys               (clk_sys),
        .rst                   (rst),
        .match_word            (match_reg[g]),
        .run                   (ctx_run[g]),
        .start_on_cycle_enable (start_on_cycle_enable[g]),
        .wait_sel              (ctx_wait_sel[2*g+1:2*g]),
        .bus_seconds_count     (bus_seconds_count),
        .bus_cycle_index       (bus_cycle_index),
        .pkt_channel           (pkt_channel),
        .pkt_tag               (pkt_tag),
        .pkt_sync              (pkt_sync),
        .accept                (accept_now[g]),
        .receiving             (recv_now[g])
      );
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pkt_accept       <= '0;
      pkt_accept_valid <= 1'b0;
      ctx_receiving    <= '0;
    end
    else
    begin
      pkt_accept       <= pkt_valid ? accept_now : '0;
      pkt_accept_valid <= pkt_valid;
      ctx_receiving    <= recv_now;
    end
  end

  // ***************************
  // checks on context 0; pointer read on context 1, reserved bits and idle accept on every context
  // ***************************
  AST_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr[15:8] == IRXF_MATCH_OFFSET[15:8]
    |=> reg_rdata[IRXF_RSVD_HI_BIT] == 1'b0 && reg_rdata[IRXF_RSVD_LO_BIT] == 1'b0)
    else $error("reserved match bit read as one");
  AST_PTR_READ: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == IRXF_PTR_OFFSET + IRXF_CTX_STRIDE |=> reg_rdata == $past(ptr_reg[1]))
    else $error("pointer read of context 1 wrong");
  AST_FETCH_ON_RUN: assert property (@(posedge clk_sys) disable iff (rst)
    ctx_run[0] && !run_prev_reg[0] && ptr_load == '0 |=> fetch_start[0] ##1 !fetch_start[0])
    else $error("fetch start not a single pulse on run");
  AST_CHANNEL: assert property (@(posedge clk_sys) disable iff (rst)
    pkt_valid && pkt_channel != match_reg[0][IRXF_CHAN_HI:0] |=> !pkt_accept[0])
    else $error("packet on other channel accepted");
  AST_TAG_EN: assert property (@(posedge clk_sys) disable iff (rst)
    pkt_valid && !match_reg[0][IRXF_TAG_EN_LO + 32'(pkt_tag)] |=> !pkt_accept[0])
    else $error("disabled tag accepted");
  AST_GATE: assert property (@(posedge clk_sys) disable iff (rst)
    pkt_valid && pkt_tag == IRXF_TAG_01 && match_reg[0][IRXF_GATE_BIT] && pkt_sync[3:2] != 2'h0
    |=> !pkt_accept[0])
    else $error("gated tag 01b packet accepted");
  AST_SYNC_WAIT: assert property (@(posedge clk_sys) disable iff (rst)
    pkt_valid && ctx_wait_sel[1:0] == IRXF_WAIT_SYNC
    && pkt_sync != match_reg[0][IRXF_SYNC_HI:IRXF_SYNC_LO] |=> !pkt_accept[0])
    else $error("sync mismatch accepted");
  AST_OTHER_TAG: assert property (@(posedge clk_sys) disable iff (rst)
    pkt_valid && recv_now[0] && pkt_tag != IRXF_TAG_01 && match_reg[0][IRXF_TAG_EN_LO + 32'(pkt_tag)]
    && pkt_channel == match_reg[0][IRXF_CHAN_HI:0] && ctx_wait_sel[1:0] != IRXF_WAIT_SYNC
    |=> pkt_accept[0])
    else $error("enabled packet rejected");
  AST_NOT_RUN: assert property (@(posedge clk_sys) disable iff (rst)
    !ctx_run[0] ##1 pkt_valid |=> !pkt_accept[0] && !ctx_receiving[0])
    else $error("stopped context accepted packet");
  AST_PTR_RO: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == IRXF_PTR_OFFSET && ptr_load == '0 |=> $stable(ptr_reg[0]))
    else $error("software write changed pointer");
  AST_FETCH_ADDR: assert property (@(posedge clk_sys) disable iff (rst)
    ctx_run[0] && !run_prev_reg[0] |=> fetch_addr == $past(ptr_reg[0]))
    else $error("fetch address not pointer of started context");
  AST_MATCH_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == IRXF_MATCH_OFFSET
    |=> match_reg[0][31:28] == $past(reg_wdata[31:28]) && !match_reg[0][IRXF_RSVD_HI_BIT]
        && !match_reg[0][IRXF_RSVD_LO_BIT])
    else $error("match write stored wrongly");
  AST_GATE_PASS: assert property (@(posedge clk_sys) disable iff (rst)
    pkt_valid && recv_now[0] && pkt_tag == IRXF_TAG_01 && match_reg[0][IRXF_TAG_EN_LO + 1]
    && match_reg[0][IRXF_GATE_BIT] && pkt_sync[3:2] == IRXF_GATE_SYNC_TOP
    && pkt_channel == match_reg[0][IRXF_CHAN_HI:0] && ctx_wait_sel[1:0] != IRXF_WAIT_SYNC
    |=> pkt_accept[0])
    else $error("gated tag 01b packet with sync top 00b rejected");
  AST_IDLE_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    !pkt_valid |=> pkt_accept == '0 && !pkt_accept_valid)
    else $error("accept shown without packet");
  AST_RUN_RECV: assert property (@(posedge clk_sys) disable iff (rst)
    !ctx_run[0] ##1 ctx_run[0] && !start_on_cycle_enable[0] |=> recv_now[0])
    else $error("context without start cycle did not start");
endmodule // irxf_top

// ### sim/irxf_link_model.sv
// ***************************
// link layer packet source
// ***************************
module irxf_link_model
(
  input  wire logic       clk_sys,
  output      logic       pkt_valid,
  output      logic [5:0] pkt_channel,
  output      logic [1:0] pkt_tag,
  output      logic [3:0] pkt_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        req = 1'b0;
  logic [11:0] hdr = 12'h000;
  initial
  begin
    pkt_valid = 1'b0;
    {pkt_channel, pkt_tag, pkt_sync} = 12'hA5C;
  end
  // header lines churn when idle, so a stale header never looks valid
  always @(posedge clk_sys)
  begin
    pkt_valid <= req;
    {pkt_channel, pkt_tag, pkt_sync} <= req ? hdr : ~{pkt_channel, pkt_tag, pkt_sync};
  end
  task automatic send(input logic [11:0] h);
    @(posedge clk_sys);
    req <= 1'b1;
    hdr <= h;
    @(posedge clk_sys);
    req <= 1'b0;
  endtask
endmodule // irxf_link_model

// ### sim/testbench.sv
module testbench;
  import irxf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_rd = 1'b0;
  logic [3:0] ctx_run = 4'h0;
  logic [3:0] soc = 4'h0;
  logic [7:0] ctx_wait_sel = 8'h00;
  logic [3:0] ptr_load = 4'h0;
  logic [31:0] ptr_value = 32'h0000_0000;
  logic [1:0] secs = 2'h0;
  logic [12:0] cyc = 13'h0000;
  logic pkt_valid, reg_rd_valid, pkt_accept_valid;
  logic [5:0] pkt_channel;
  logic [1:0] pkt_tag;
  logic [3:0] pkt_sync, pkt_accept, ctx_receiving, fetch_start, act = 4'h0;
  logic [31:0] reg_rdata, fetch_addr, m, mw[4], pw[4];
  logic [31:0] q_rd[$];
  logic [3:0] q_acc[$];
  logic [35:0] q_f[$];
  integer seed = 32'h4a1ef508;
  int fail_count = 0;
  int n_compared = 0;
  always #12.5 clk_sys = ~clk_sys;
  irxf_top i_irxf_top (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .ctx_run(ctx_run), .start_on_cycle_enable(soc), .ctx_wait_sel(ctx_wait_sel), .ptr_load(ptr_load),
    .ptr_value(ptr_value), .bus_seconds_count(secs), .bus_cycle_index(cyc), .pkt_valid(pkt_valid),
    .pkt_channel(pkt_channel), .pkt_tag(pkt_tag), .pkt_sync(pkt_sync), .pkt_accept(pkt_accept),
    .pkt_accept_valid(pkt_accept_valid), .ctx_receiving(ctx_receiving), .fetch_start(fetch_start),
    .fetch_addr(fetch_addr));
  irxf_link_model i_irxf_link_model (.clk_sys(clk_sys), .pkt_valid(pkt_valid),
    .pkt_channel(pkt_channel), .pkt_tag(pkt_tag), .pkt_sync(pkt_sync));
  // ***************************
  // shared tasks
  // ***************************
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    q_rd.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  function automatic logic ok(input logic [31:0] mm, input logic [1:0] w, input logic [11:0] h);
    return h[11:6] == mm[5:0] && mm[28 + h[5:4]] && !(mm[6] && h[5:4] == 2'h1 && h[3:2] != 2'h0)
      && (w != 2'h3 || h[3:0] == mm[11:8]);
  endfunction
  task automatic pkt(input logic [11:0] h);
    logic [3:0] e;
    for (int i = 0; i < 4; i++)
      e[i] = act[i] & ok(mw[i], ctx_wait_sel[2*i +: 2], h);
    q_acc.push_back(e);
    i_irxf_link_model.send(h);
    tick(2);
    @(negedge clk_sys);
    check(ctx_receiving, act);
    @(posedge clk_sys);
  endtask
  function automatic logic [15:0] at(input logic [15:0] base, input int n);
    return base + 16'(n) * IRXF_CTX_STRIDE;
  endfunction
  // ***************************
  // result watcher
  // ***************************
  always @(negedge clk_sys)
  begin
    if (reg_rd_valid === 1'b1) check(reg_rdata, q_rd.pop_front());
    if (pkt_accept_valid === 1'b1) check(pkt_accept, q_acc.pop_front());
    if (fetch_start !== 4'h0) check({fetch_start, fetch_addr}, q_f.pop_front());
  end
  initial
  begin
    tick(20000);
    fail_count++;
    report_and_stop();
  end
  // ***************************
  // scenarios
  // ***************************
  initial
  begin
    tick(6);
    rst <= 1'b0;
    rd(16'h0410, 32'h0);
    for (int n = 0; n < 4; n++)
    begin
      rd(at(IRXF_MATCH_OFFSET, n), 32'h0);
      wr(at(IRXF_MATCH_OFFSET, n), 32'hFFFF_FFFF);
      rd(at(IRXF_MATCH_OFFSET, n), 32'hF7FF_FF7F);
      mw[n] = 32'hF7FF_FF7F;
      pw[n] = $random(seed);
      @(posedge clk_sys);
      ptr_load <= 4'h1 << n;
      ptr_value <= pw[n];
      @(posedge clk_sys);
      ptr_load <= 4'h0;
      wr(at(IRXF_PTR_OFFSET, n), ~pw[n]);
      rd(at(IRXF_PTR_OFFSET, n), pw[n]);
    end
    // start-on-cycle: seconds mismatch alone must keep the context waiting
    mw[1] = 32'hF412_302A;
    wr(at(IRXF_MATCH_OFFSET, 1), mw[1]);
    q_f.push_back({4'h2, pw[1]});
    soc <= 4'h2;
    ctx_run <= 4'h2;
    secs <= 2'h1;
    cyc <= 13'h0123;
    tick(4);
    pkt({6'h2A, 2'h0, 4'h5});
    secs <= 2'h2;
    tick(1);
    cyc <= 13'h0124;
    tick(3);
    act[1] = 1'b1;
    pkt({6'h2A, 2'h0, 4'h5});
    q_f.push_back({4'h1, pw[0]});
    ctx_run <= 4'h3;
    tick(4);
    act[0] = 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      m = $random(seed);
      if (r > 1) m = m | 32'h2000_0040;
      mw[0] = m & 32'hF7FF_FF7F;
      ctx_wait_sel[1:0] <= 2'(r);
      wr(at(IRXF_MATCH_OFFSET, 0), m);
      rd(at(IRXF_MATCH_OFFSET, 0), mw[0]);
      repeat (16)
      begin
        m = $random(seed);
        if (m[12]) m[11:6] = mw[0][5:0];
        if (m[13]) m[3:0] = mw[0][11:8];
        pkt(m[11:0]);
      end
    end
    // run cleared by software: a packet sent three cycles later on that context is not accepted
    ctx_run <= 4'h2;
    tick(3);
    act[0] = 1'b0;
    pkt({mw[0][5:0], 2'h0, mw[0][11:8]});
    tick(4);
    check(36'(q_rd.size() + q_acc.size() + q_f.size()), 36'h0);
    report_and_stop();
  end
endmodule // testbench
